// *** hdl/dio_direction_output_port.sv ***
/*
  general-purpose digital pin port: twenty bidirectional lines and two
  output-only lines over avalon-mm; bidirectional lines driven from masked set/clear updates.
  assumes pins and peripheral ownership inputs are synchronous to mclk.
*/
// Functional notes
// R01: twenty bidirectional lines on mask bits 0..19; bits 20..31 are ignored.
// R02: two output-only lines, indexed zero and one, configured separately.
// R03: after reset every bidirectional line is an input with driver off.
// R04: direction update uses input and output masks; unnamed lines keep direction.
// R05: a line named in both direction masks becomes an input.
// R06: direction update for an owned line is stored, applied when owner releases.
// R07: direction update never touches pull-up; pull-ups have their own update.
// R08: output update uses drive-high and drive-low masks; unnamed lines hold value.
// R09: a line named in both output masks becomes low.
// R10: output value on an input line is kept, driven once it becomes output.
// R11: output value on an owned line reaches the pin only after release.
// R12: an enabled sharing peripheral controls the pin; general use unavailable.
// R13: input lines are capable of raising interrupts and waking the device; the code has no interrupt and sets wake_capable only on input lines not owned.
// R14: input read returns every pin level; unused bits read zero.
// R15: output latches reset low, so a fresh output line drives low.
`timescale 1ns/100ps
module dio_direction_output_port
  import dio_port_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]     address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [DATA_W-1:0]     writedata,
  output logic      [DATA_W-1:0]     readdata,
  output logic                       waitrequest,
  // bidirectional pin lines
  input  wire logic [LINE_COUNT-1:0] bidir_pin_line_in,
  output logic      [LINE_COUNT-1:0] bidir_pin_line_out,
  output logic      [LINE_COUNT-1:0] bidir_pin_line_oe_n,
  output logic      [LINE_COUNT-1:0] pullup_en,
  output logic      [LINE_COUNT-1:0] wake_capable,
  // sharing peripherals
  input  wire logic [LINE_COUNT-1:0] periph_own,
  input  wire logic [LINE_COUNT-1:0] periph_out,
  input  wire logic [LINE_COUNT-1:0] periph_drive,
  // output-only lines
  output logic      [DO_COUNT-1:0]   do_line_out,
  output logic      [DO_COUNT-1:0]   do_line_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  bus_req_type              req;
  bus_state_type            bus_state_q;
  bus_state_type            bus_state_d;
  logic                     waitrequest_q;
  logic [DATA_W-1:0]        readdata_q;
  logic [DATA_W-1:0]        rd_mux;
  logic [DATA_W-1:0]        be_mask;
  logic                     req_take;
  logic                     wr_fire;
  logic                     rd_take;

  assign req      = '{read: read, write: write, address: address,
                      byteenable: byteenable, writedata: writedata};
  assign req_take = (bus_state_q == BUS_IDLE) && (req.read || req.write);
  assign rd_take  = req_take && req.read;
  // a write lands on the edge where the master sees waitrequest low
  assign wr_fire  = (bus_state_q == BUS_ACK) && req.write;
  assign be_mask  = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                     {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

  always_comb begin
    case (bus_state_q)
      BUS_IDLE: bus_state_d = req_take ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_state_d = BUS_IDLE;
      default:  bus_state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q   <= BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q    <= WORD_ZERO;
    end else begin
      bus_state_q   <= bus_state_d;
      waitrequest_q <= ~req_take;
      if (rd_take) begin
        readdata_q <= rd_mux;
      end
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;

  ////////////////////////////////////////////////////////////////////////////
  // staged masks and update command

  logic [LINE_COUNT-1:0] in_sel_q;
  logic [LINE_COUNT-1:0] out_sel_q;
  logic [LINE_COUNT-1:0] hi_sel_q;
  logic [LINE_COUNT-1:0] lo_sel_q;
  logic [LINE_COUNT-1:0] pon_sel_q;
  logic [LINE_COUNT-1:0] poff_sel_q;
  logic [DATA_W-1:0]     do_ctrl_q;
  logic [LINE_COUNT-1:0] wr_val;
  logic [DATA_W-1:0]     do_wr_val;
  logic                  wr_in_sel;
  logic                  wr_out_sel;
  logic                  wr_hi_sel;
  logic                  wr_lo_sel;
  logic                  wr_pon;
  logic                  wr_poff;
  logic                  wr_apply;
  logic                  wr_do;
  apply_type             apply;

  assign wr_in_sel  = wr_fire && (req.address == OFF_IN_SEL);
  assign wr_out_sel = wr_fire && (req.address == OFF_OUT_SEL);
  assign wr_hi_sel  = wr_fire && (req.address == OFF_HI_SEL);
  assign wr_lo_sel  = wr_fire && (req.address == OFF_LO_SEL);
  assign wr_pon     = wr_fire && (req.address == OFF_PULL_ON);
  assign wr_poff    = wr_fire && (req.address == OFF_PULL_OFF);
  assign wr_apply   = wr_fire && (req.address == OFF_APPLY) && req.byteenable[0];
  assign wr_do      = wr_fire && (req.address == OFF_DO_CTRL);

  // bits 20..31 of every mask are dropped here, so they never reach a line
  assign wr_val    = req.writedata[LINE_COUNT-1:0] & be_mask[LINE_COUNT-1:0];   // [R01]
  assign do_wr_val = (req.writedata & be_mask) | (do_ctrl_q & ~be_mask);

  // masks are staged separately and committed together so both halves of an
  // update land on the same edge; the cost is one extra write per update
  assign apply.dir  = wr_apply && req.writedata[APPLY_DIR_BIT];    // [R04]
  assign apply.out  = wr_apply && req.writedata[APPLY_OUT_BIT];    // [R08]
  assign apply.pull = wr_apply && req.writedata[APPLY_PULL_BIT];   // [R07]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_sel_q   <= MASK_RST;
      out_sel_q  <= MASK_RST;
      hi_sel_q   <= MASK_RST;
      lo_sel_q   <= MASK_RST;
      pon_sel_q  <= MASK_RST;
      poff_sel_q <= MASK_RST;
      do_ctrl_q  <= WORD_ZERO;
    end else begin
      if (wr_in_sel)  in_sel_q   <= wr_val;
      if (wr_out_sel) out_sel_q  <= wr_val;
      if (wr_hi_sel)  hi_sel_q   <= wr_val;
      if (wr_lo_sel)  lo_sel_q   <= wr_val;
      if (wr_pon)     pon_sel_q  <= wr_val;
      if (wr_poff)    poff_sel_q <= wr_val;
      if (wr_do)      do_ctrl_q  <= do_wr_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line cells

  logic [LINE_COUNT-1:0] dir_state;
  logic [LINE_COUNT-1:0] val_state;
  logic [LINE_COUNT-1:0] pull_state;

  for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
    dio_line_cell #(
      .DIR_INIT  (DIR_RST),
      .PULL_INIT (PULL_RST)
    ) u_cell (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .apply        (apply),
      .in_sel       (in_sel_q[i]),
      .out_sel      (out_sel_q[i]),
      .hi_sel       (hi_sel_q[i]),
      .lo_sel       (lo_sel_q[i]),
      .pull_on      (pon_sel_q[i]),
      .pull_off     (poff_sel_q[i]),
      .own          (periph_own[i]),
      .periph_out   (periph_out[i]),
      .periph_drive (periph_drive[i]),
      .dir_q        (dir_state[i]),
      .val_q        (val_state[i]),
      .pull_q       (pull_state[i]),
      .pad_out_q    (bidir_pin_line_out[i]),
      .pad_oe_n_q   (bidir_pin_line_oe_n[i]),
      .wake_cap_q   (wake_capable[i])
    );
  end

  assign pullup_en = pull_state;

  ////////////////////////////////////////////////////////////////////////////
  // output-only lines

  logic [DO_COUNT-1:0] do_out_q;
  logic [DO_COUNT-1:0] do_oe_n_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      do_out_q  <= DO_RST;
      do_oe_n_q <= ~DO_RST;
    end else begin
      do_out_q  <= do_ctrl_q[DO_DATA_LSB +: DO_COUNT];    // [R02]
      do_oe_n_q <= ~do_ctrl_q[DO_EN_LSB +: DO_COUNT];     // [R02]
    end
  end

  assign do_line_out  = do_out_q;
  assign do_line_oe_n = do_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // read selection

  logic [UNUSED_W-1:0] pad_zero;
  logic [DATA_W-1:0]   do_rd;

  assign pad_zero = '0;
  assign do_rd    = do_ctrl_q & ({{(DATA_W-DO_DATA_LSB-DO_COUNT){1'b0}}, {DO_COUNT{1'b1}},
                                  {(DO_DATA_LSB-DO_COUNT){1'b0}}, {DO_COUNT{1'b1}}});

  always_comb begin
    case (req.address)
      OFF_IN_SEL:    rd_mux = {pad_zero, in_sel_q};
      OFF_OUT_SEL:   rd_mux = {pad_zero, out_sel_q};
      OFF_HI_SEL:    rd_mux = {pad_zero, hi_sel_q};
      OFF_LO_SEL:    rd_mux = {pad_zero, lo_sel_q};
      OFF_PULL_ON:   rd_mux = {pad_zero, pon_sel_q};
      OFF_PULL_OFF:  rd_mux = {pad_zero, poff_sel_q};
      OFF_DIR_STAT:  rd_mux = {pad_zero, dir_state};
      OFF_OUT_STAT:  rd_mux = {pad_zero, val_state};
      OFF_PULL_STAT: rd_mux = {pad_zero, pull_state};
      OFF_LEVEL:     rd_mux = {pad_zero, bidir_pin_line_in};   // [R14]
      OFF_DO_CTRL:   rd_mux = do_rd;
      OFF_WAKE_CAP:  rd_mux = {pad_zero, wake_capable};        // [R13]
      default:       rd_mux = WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic dir_touched_q;
  logic out_touched_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_touched_q <= 1'b0;
      out_touched_q <= 1'b0;
    end else begin
      dir_touched_q <= dir_touched_q | apply.dir;
      out_touched_q <= out_touched_q | apply.out;
    end
  end

  sequence s_dir_commit;
    apply.dir;
  endsequence

  sequence s_out_commit;
    apply.out;
  endsequence

  sequence s_level_read;
    rd_take && (req.address == OFF_LEVEL);
  endsequence

  property p_reset_inputs;
    @(posedge mclk) disable iff (!rst_n)
    !dir_touched_q |-> (dir_state == MASK_RST) ##1 (&bidir_pin_line_oe_n || periph_own != MASK_RST);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("line left input state without update"); // [R03]

  property p_dir_update;
    @(posedge mclk) disable iff (!rst_n)
    s_dir_commit |=> dir_state == (($past(dir_state) | $past(out_sel_q)) & ~$past(in_sel_q));
  endproperty
  a_dir_update: assert property (p_dir_update) else $error("direction update wrong"); // [R04]

  property p_dir_both_input;
    @(posedge mclk) disable iff (!rst_n)
    s_dir_commit and (|(in_sel_q & out_sel_q)) |=> (dir_state & $past(in_sel_q & out_sel_q)) == MASK_RST;
  endproperty
  a_dir_both_input: assert property (p_dir_both_input) else $error("both-mask line not input"); // [R05]

  property p_owned_pad;
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> ((bidir_pin_line_oe_n ^ ~$past(periph_drive)) & $past(periph_own)) == MASK_RST;
  endproperty
  a_owned_pad: assert property (p_owned_pad) else $error("owned pad not under peripheral"); // [R06]

  property p_pull_kept;
    @(posedge mclk) disable iff (!rst_n)
    !apply.pull |=> $stable(pull_state);
  endproperty
  a_pull_kept: assert property (p_pull_kept) else $error("pull-up changed without its update"); // [R07]

  property p_out_update;
    @(posedge mclk) disable iff (!rst_n)
    s_out_commit |=> val_state == (($past(val_state) | $past(hi_sel_q)) & ~$past(lo_sel_q));
  endproperty
  a_out_update: assert property (p_out_update) else $error("output update wrong"); // [R08]

  property p_out_both_low;
    @(posedge mclk) disable iff (!rst_n)
    s_out_commit and (|(hi_sel_q & lo_sel_q)) |=> (val_state & $past(hi_sel_q & lo_sel_q)) == MASK_RST;
  endproperty
  a_out_both_low: assert property (p_out_both_low) else $error("both-mask line not low"); // [R09]

  property p_input_undriven;
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> &(bidir_pin_line_oe_n | $past(dir_state) | $past(periph_own));
  endproperty
  a_input_undriven: assert property (p_input_undriven) else $error("input line driven"); // [R10]

  property p_pad_source;
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> bidir_pin_line_out == (($past(periph_own) & $past(periph_out))
                                   | (~$past(periph_own) & $past(val_state)));
  endproperty
  a_pad_source: assert property (p_pad_source) else $error("pad value from wrong source"); // [R11] [R12]

  property p_wake_cap;
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> wake_capable == ($past(~dir_state) & $past(~periph_own));
  endproperty
  a_wake_cap: assert property (p_wake_cap) else $error("wake capability wrong"); // [R13]

  property p_level_read;
    @(posedge mclk) disable iff (!rst_n)
    s_level_read |=> !waitrequest ##0 (readdata == {pad_zero, $past(bidir_pin_line_in)});
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read mismatch"); // [R14] [R01]

  property p_latch_reset_low;
    @(posedge mclk) disable iff (!rst_n)
    !out_touched_q |-> val_state == MASK_RST;
  endproperty
  a_latch_reset_low: assert property (p_latch_reset_low) else $error("output latch not low"); // [R15]

  property p_do_follow;
    @(posedge mclk) disable iff (!rst_n)
    wr_do |=> ##1 do_line_out == $past(do_ctrl_q[DO_DATA_LSB +: DO_COUNT]);
  endproperty
  a_do_follow: assert property (p_do_follow) else $error("output-only line lagging"); // [R02]

  property p_wait_one;
    @(posedge mclk) disable iff (!rst_n)
    req_take |=> !waitrequest ##1 waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");

endmodule // dio_direction_output_port

// *** hdl/dio_line_cell.sv ***
/*
  one bidirectional pin line: direction, output latch and pull-up state,
  and the registered pad drive, with the sharing peripheral taking precedence.
  assumes apply strobes are single-cycle and masks are stable when they fire.
*/
`timescale 1ns/100ps
module dio_line_cell
  import dio_port_pkg::*;
#(
  parameter logic DIR_INIT  = DIR_RST,
  parameter logic PULL_INIT = PULL_RST
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // update strobes and this line's mask bits
  input  wire apply_type apply,
  input  wire logic  in_sel,
  input  wire logic  out_sel,
  input  wire logic  hi_sel,
  input  wire logic  lo_sel,
  input  wire logic  pull_on,
  input  wire logic  pull_off,
  // sharing peripheral
  input  wire logic  own,
  input  wire logic  periph_out,
  input  wire logic  periph_drive,
  // state and pad
  output logic       dir_q,
  output logic       val_q,
  output logic       pull_q,
  output logic       pad_out_q,
  output logic       pad_oe_n_q,
  output logic       wake_cap_q
);

  logic dir_d;
  logic val_d;
  logic pull_d;

  // input select wins over output select; low wins over high; off wins over on
  assign dir_d  = apply.dir  ? ((dir_q | out_sel) & ~in_sel) : dir_q;   // [R04] [R05]
  assign val_d  = apply.out  ? ((val_q | hi_sel) & ~lo_sel)  : val_q;   // [R08] [R09]
  assign pull_d = apply.pull ? ((pull_q | pull_on) & ~pull_off) : pull_q; // [R07]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q      <= DIR_INIT;        // [R03]
      val_q      <= VAL_RST;         // [R15]
      pull_q     <= PULL_INIT;
      pad_out_q  <= VAL_RST;
      pad_oe_n_q <= 1'b1;            // [R03]
      wake_cap_q <= 1'b0;
    end else begin
      dir_q      <= dir_d;           // [R06] stored even while owned
      val_q      <= val_d;           // [R10] [R11] latched regardless of pad use
      pull_q     <= pull_d;
      pad_out_q  <= own ? periph_out : val_q;          // [R11] [R12]
      pad_oe_n_q <= own ? ~periph_drive : ~dir_q;      // [R06] [R10] [R12]
      wake_cap_q <= ~dir_q & ~own;                     // [R13]
    end
  end

endmodule // dio_line_cell

// *** hdl/dio_port_pkg.sv ***
/*
  constants and carrier types for the general-purpose digital pin port:
  register offsets, field positions, reset values and the bus request record.
  assumes a 32-bit avalon-mm slave with byte addresses.
*/
package dio_port_pkg;

  localparam int unsigned LINE_COUNT = 20;
  localparam int unsigned DO_COUNT   = 2;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned UNUSED_W   = DATA_W - LINE_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IN_SEL    = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_OUT_SEL   = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_HI_SEL    = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_LO_SEL    = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_PULL_ON   = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PULL_OFF  = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_APPLY     = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_DIR_STAT  = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_OUT_STAT  = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_PULL_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_LEVEL     = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_DO_CTRL   = 6'h2c;
  localparam logic [ADDR_W-1:0] OFF_WAKE_CAP  = 6'h30;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned APPLY_DIR_BIT  = 0;
  localparam int unsigned APPLY_OUT_BIT  = 1;
  localparam int unsigned APPLY_PULL_BIT = 2;
  localparam int unsigned DO_EN_LSB      = 0;
  localparam int unsigned DO_DATA_LSB    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic             DIR_RST     = 1'b0;
  localparam logic             VAL_RST     = 1'b0;
  localparam logic             PULL_RST    = 1'b1;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [DO_COUNT-1:0] DO_RST   = 2'h0;
  localparam logic [LINE_COUNT-1:0] MASK_RST = 20'h00000;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } bus_req_type;

  typedef struct packed {
    logic pull;
    logic out;
    logic dir;
  } apply_type;

endpackage : dio_port_pkg

// *** tb/dio_direction_output_port_test.sv ***
/*
  self-checking bench for the digital pin port: register sequences over
  avalon-mm with checks on pads. assumes one wait cycle is not relied on.
*/
`timescale 1ns/100ps
module dio_direction_output_port_test;
  import dio_port_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [5:0]  address = '0;
  logic [31:0] writedata = '0, readdata;
  logic        waitrequest;
  logic [19:0] lvl, pout, poe_n, pull, wake, ext_en = '0, ext_val = '0;
  logic [19:0] own = '0, p_out = '0, p_drv = '0;
  logic [1:0]  do_out, do_oe_n;
  int          failures = 0, n_tests = 0;

  always #5 mclk = ~mclk;

  dio_direction_output_port dut (.mclk(mclk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .bidir_pin_line_in(lvl), .bidir_pin_line_out(pout),
    .bidir_pin_line_oe_n(poe_n), .pullup_en(pull), .wake_capable(wake),
    .periph_own(own), .periph_out(p_out), .periph_drive(p_drv),
    .do_line_out(do_out), .do_line_oe_n(do_oe_n));

  dio_pin_model pins (.mclk(mclk), .pad_out(pout), .pad_oe_n(poe_n),
    .pull_en(pull), .ext_en(ext_en), .ext_val(ext_val), .level(lvl));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    read <= is_rd;
    write <= ~is_rd;
    address <= a;
    writedata <= d;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    check(readdata, exp);
  endtask

  // pads lag state by one edge, output-only lines their control register by one edge too
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic conclude;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    rd(OFF_DIR_STAT, 32'h0);
    rd(OFF_OUT_STAT, 32'h0);
    check(32'(poe_n), 32'h000f_ffff);
    check(32'(wake), 32'h000f_ffff);
    wr(OFF_OUT_SEL, 32'hffff_ffff);
    rd(OFF_OUT_SEL, 32'h000f_ffff);
    wr(OFF_IN_SEL, 32'h0);
    wr(OFF_APPLY, 32'h1);
    settle();
    rd(OFF_DIR_STAT, 32'h000f_ffff);
    check(32'(pout), 32'h0);
    check(32'(poe_n), 32'h0);
    rd(OFF_PULL_STAT, 32'h000f_ffff);
    // both masks on bits 0..3 and 12..15; bits 16..19 inputs only
    wr(OFF_IN_SEL, 32'h000f_f00f);
    wr(OFF_OUT_SEL, 32'h0000_f0ff);
    wr(OFF_APPLY, 32'h1);
    settle();
    rd(OFF_DIR_STAT, 32'h0000_0ff0);
    check(32'(wake), 32'h000f_f00f);
    wr(OFF_HI_SEL, 32'h0000_3f30);
    wr(OFF_LO_SEL, 32'h0000_0f00);
    wr(OFF_APPLY, 32'h2);
    settle();
    rd(OFF_OUT_STAT, 32'h0000_3030);
    check(32'(pout & ~poe_n), 32'h0000_0030);
    check(32'(poe_n[13:12]), 32'h3);
    ext_en <= 20'hff00f;
    ext_val <= 20'ha500a;
    rd(OFF_LEVEL, 32'h000a_503a);
    wr(OFF_PULL_ON, 32'h1);
    wr(OFF_PULL_OFF, 32'h1);
    wr(OFF_APPLY, 32'h4);
    rd(OFF_PULL_STAT, 32'h000f_fffe);
    check(32'(pull), 32'h000f_fffe);
    ext_en <= 20'h0;
    wr(OFF_IN_SEL, 32'h0);
    wr(OFF_OUT_SEL, 32'h0000_1000);
    wr(OFF_APPLY, 32'h1);
    settle();
    check(32'({pout[12], poe_n[12]}), 32'h2);
    // lines 4 and 5 taken over by a sharing peripheral
    own <= 20'h30;
    p_drv <= 20'h30;
    wr(OFF_IN_SEL, 32'h10);
    wr(OFF_OUT_SEL, 32'h0);
    wr(OFF_HI_SEL, 32'h0);
    wr(OFF_LO_SEL, 32'h20);
    wr(OFF_APPLY, 32'h3);
    settle();
    check(32'({pout[5:4], poe_n[5:4]}), 32'h0);
    p_out <= 20'h30;
    settle();
    check(32'({pout[5:4], poe_n[5:4]}), 32'hc);
    check(32'(wake[5:4]), 32'h0);
    rd(OFF_DIR_STAT, 32'h0000_1fe0);
    own <= 20'h0;
    p_drv <= 20'h0;
    settle();
    check(32'({poe_n[4], poe_n[5], pout[5]}), 32'h4);
    check(32'(wake[4]), 32'h1);
    wr(OFF_DO_CTRL, 32'h0000_0201);
    settle();
    check(32'({do_out, do_oe_n}), 32'ha);
    rd(OFF_DO_CTRL, 32'h0000_0201);
    wr(OFF_DO_CTRL, 32'h0000_0102);
    settle();
    check(32'({do_out, do_oe_n}), 32'h5);
    rd(6'h34, 32'h0);
    rd(OFF_APPLY, 32'h0);
    conclude();
  end
endmodule // dio_direction_output_port_test

// *** tb/dio_pin_model.sv ***
/*
  external circuitry on the bidirectional pins: resolves each line's level.
  assumes pad drive outputs are active-low enabled and pull-ups pull high.
*/
`timescale 1ns/100ps
module dio_pin_model (
  // clock
  input  wire logic        mclk,
  // pad side of the port
  input  wire logic [19:0] pad_out,
  input  wire logic [19:0] pad_oe_n,
  input  wire logic [19:0] pull_en,
  // far-side drivers
  input  wire logic [19:0] ext_en,
  input  wire logic [19:0] ext_val,
  // resolved level
  output logic      [19:0] level
);
  logic [19:0] float_q;

  // an undriven line without pull-up wanders, so no stale value can pass
  // plain always: the initial block below also writes this register
  always @(posedge mclk) begin
    float_q <= ~float_q;
  end
  initial float_q = 20'h5a5a5;

  assign level = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val) |
                 (pad_oe_n & ~ext_en & (pull_en | float_q));
endmodule // dio_pin_model
